/* File: verilog/ssq_pkg.sv */
package ssq_pkg;

	// Register word indexes on the host word port: six output words, then two input words.
	localparam logic [2:0] OW_CTRL = 3'h0;
	localparam logic [2:0] OW_MASK = 3'h1;
	localparam logic [2:0] OW_CLEAR = 3'h2;
	localparam logic [2:0] OW_LAST = 3'h5;
	localparam logic [2:0] IW_STATUS = 3'h6;
	localparam logic [2:0] IW_COUNT = 3'h7;
	localparam int NUM_OUT_WORDS = 6;

	// Control word bit positions.
	localparam int CTRL_ASCII = 0;
	localparam int CTRL_ONE_BASED = 1;
	localparam int CTRL_COIL_RELAY = 2;
	localparam int CTRL_EXT32 = 3;
	localparam int CTRL_LOOPBACK = 4;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Sticky event bits, same layout in status, mask and clear words.
	localparam int EV_DONE = 0;
	localparam int EV_OVERRUN = 1;
	localparam int EV_LOOP_RX = 2;
	localparam int NUM_EV = 3;

	// Protocol variable classes carried in the first query byte.
	localparam logic [1:0] CLS_COIL = 2'h0;
	localparam logic [1:0] CLS_INPUT = 2'h1;
	localparam logic [1:0] CLS_HOLDING = 2'h2;
	localparam logic [1:0] CLS_INREG = 2'h3;

	// Host memory types asked for on the memory request port.
	localparam logic [2:0] MEM_DISCRETE_OUT = 3'h0;
	localparam logic [2:0] MEM_INTERNAL_RELAY = 3'h1;
	localparam logic [2:0] MEM_DISCRETE_IN = 3'h2;
	localparam logic [2:0] MEM_VARIABLE = 3'h3;
	localparam logic [2:0] MEM_PLC_INPUT_WORD = 3'h4;

	// Query length in bytes: class, address high, address low, count high, count low.
	localparam logic [2:0] QUERY_BYTES = 3'h5;

	// Loopback test pattern runs over the printable characters.
	localparam logic [7:0] LOOP_FIRST = 8'h20;
	localparam logic [7:0] LOOP_LAST = 8'h7e;

	// Indicator timing.
	localparam int CLK_MHZ = 200;
	localparam int LED_HOLD_MS = 50;
	localparam int LED_HOLD_CYC = LED_HOLD_MS * 1000 * CLK_MHZ;

endpackage

/* File: verilog/ssq_hex_enc.sv */
`timescale 1ns/10ps
// Passes bytes straight through in binary framing, or splits each byte into two hex characters.
module ssq_hex_enc
(
	input wire logic i_ref_clk, // System clock.
	input wire logic i_reset_n, // Asynchronous reset, active low.
	input wire logic i_ascii, // High selects hex character output.
	input wire logic i_valid, // Byte offered.
	input wire logic [7:0] i_byte, // Byte to send.
	output logic o_ready, // Byte taken this cycle when valid.
	output logic o_valid, // Character or byte on the line side.
	output logic [7:0] o_byte, // Character or byte value.
	input wire logic i_ready // Line side takes the output.
);

	typedef struct packed
	{
		logic busy;
		logic low;
		logic [7:0] hold;
		logic [7:0] out;
	} ssq_enc_t;

	ssq_enc_t s_q, s_d;

	// Maps a nibble to its upper-case hex character.
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'ha) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
	endfunction

	// Takes a new byte only when idle, then sends it whole, or in hex framing sends high nibble then low nibble.
	always_comb
	begin
		s_d = s_q;
		if (s_q.busy && i_ready)
		begin
			if (i_ascii && !s_q.low)
			begin
				s_d.low = 1'b1;
				s_d.out = hex_char(s_q.hold[3:0]); // see RQ11
			end
			else
			begin
				s_d.busy = 1'b0;
			end
		end
		if (i_valid && !s_q.busy)
		begin
			s_d.busy = 1'b1;
			s_d.low = 1'b0;
			s_d.hold = i_byte;
			s_d.out = i_ascii ? hex_char(i_byte[7:4]) : i_byte; // see RQ2 see RQ11
		end
	end

	// State register.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_ready = !s_q.busy;
	assign o_valid = s_q.busy;
	assign o_byte = s_q.out;

endmodule

/* File: verilog/ssq_query_mapper.sv */
`timescale 1ns/10ps
// Functional notes
// RQ1 - Host sees two input words and six output words on its word port.
// RQ2 - Queries and responses work in binary and in hex character framing.
// RQ3 - Decode query, request host memory, await reply, then send response.
// RQ4 - One control bit selects between the two relative address bases.
// RQ5 - Standard mode: query addresses count from zero.
// RQ6 - Legacy one based mode: query addresses count from one.
// RQ7 - Coils map to discrete outputs or relays; 32-bit option forces relays.
// RQ8 - With the 32-bit option each register item moves two words.
// RQ9 - First discrete item goes to bit 0, filling upward byte by byte.
// RQ10 - Unused high bits of the last discrete byte are zero.
// RQ11 - Hex framing sends each byte as two characters, high nibble first.
// RQ12 - Active indicator steady when diagnostics pass, blinking on a hardware fault.
// RQ13 - Loopback pulses transmit indicator while sending, receive indicator on return.
// RQ14 - Only terminal slave protocols run without host logic; this block needs it.
// RQ15 - Loopback sends a running series of printable characters on the port.
module ssq_query_mapper
#(
	parameter int LED_HOLD_CYC = ssq_pkg::LED_HOLD_CYC // Indicator pulse and blink half period.
)
(
	input wire logic i_ref_clk, // System clock, 200 MHz.
	input wire logic i_reset_n, // Asynchronous reset, active low.
	input wire logic [2:0] i_addr, // Host word index.
	input wire logic [15:0] i_wdata, // Host write data.
	input wire logic i_wr, // Host write strobe.
	input wire logic i_rd, // Host read strobe.
	output logic [15:0] o_rdata, // Read data, valid the cycle after the strobe.
	output logic o_irq, // Level interrupt.
	input wire logic i_rx_valid, // Received byte or character strobe.
	input wire logic [7:0] i_rx_byte, // Received byte or character.
	output logic o_tx_valid, // Transmit byte or character offered.
	output logic [7:0] o_tx_byte, // Transmit byte or character.
	input wire logic i_tx_ready, // Transmitter takes the byte.
	output logic o_mem_req, // Host memory read request, held until acknowledged.
	output logic [2:0] o_mem_type, // Host memory type.
	output logic [15:0] o_mem_addr, // One based host item address.
	input wire logic i_mem_ack, // Host reply strobe.
	input wire logic [15:0] i_mem_data, // Host reply data, bit 0 for discrete items.
	input wire logic i_diag_done, // Power-up diagnostics finished.
	input wire logic i_diag_fault, // Diagnostics found a hardware fault.
	output logic o_active_led, // Active indicator.
	output logic o_transmit_indicator, // Transmit indicator.
	output logic o_receive_indicator // Receive indicator.
);

	localparam int NUM_OUT_WORDS_W = ssq_pkg::NUM_OUT_WORDS;

	typedef enum logic [6:0]
	{
		ST_IDLE = 7'b0000001,
		ST_RXQ = 7'b0000010,
		ST_REQ = 7'b0000100,
		ST_EMIT = 7'b0001000,
		ST_DONE = 7'b0010000,
		ST_LOOP = 7'b0100000,
		ST_HDR = 7'b1000000
	} ssq_state_t;

	typedef struct packed
	{
		ssq_state_t st;
		logic [2:0] nbytes;
		logic nib_ok;
		logic [3:0] nib;
		logic [1:0] cls;
		logic [15:0] base;
		logic [15:0] cnt;
		logic [15:0] item;
		logic [7:0] sh;
		logic [2:0] bitn;
		logic [15:0] wbuf;
		logic lowbyte;
		logic byte_ok;
		logic [7:0] tx_byte;
		logic [NUM_OUT_WORDS_W-1:0][15:0] wy;
		logic [2:0] ev;
		logic [15:0] rdata;
		logic [7:0] loop_ch;
		logic [31:0] tx_led;
		logic [31:0] rx_led;
		logic [31:0] blink;
		logic blink_on;
		logic gap;
	} ssq_top_t;
	localparam logic [31:0] HOLD = 32'(LED_HOLD_CYC);

	ssq_top_t s_q, s_d;
	logic enc_ready;
	logic rx_ok;
	logic [7:0] rx_val;
	logic discrete;
	logic [15:0] ctrl;
	logic [2:0] ev_set;

	// Turns a hex character into its nibble.
	function automatic logic [3:0] hex_val(input logic [7:0] c);
		hex_val = (c >= 8'h41) ? 4'(c[3:0] + 4'h9) : c[3:0];
	endfunction

	assign ctrl = s_q.wy[ssq_pkg::OW_CTRL];
	assign discrete = (s_q.cls == ssq_pkg::CLS_COIL) || (s_q.cls == ssq_pkg::CLS_INPUT);

	// Host memory type and item address for the current item.
	always_comb
	begin
		case (s_q.cls)
			ssq_pkg::CLS_COIL: o_mem_type = (ctrl[ssq_pkg::CTRL_COIL_RELAY] || ctrl[ssq_pkg::CTRL_EXT32]) ?
				ssq_pkg::MEM_INTERNAL_RELAY : ssq_pkg::MEM_DISCRETE_OUT; // see RQ7
			ssq_pkg::CLS_INPUT: o_mem_type = ssq_pkg::MEM_DISCRETE_IN;
			ssq_pkg::CLS_HOLDING: o_mem_type = ssq_pkg::MEM_VARIABLE;
			default: o_mem_type = ssq_pkg::MEM_PLC_INPUT_WORD;
		endcase
		// Zero based queries need one added; one based queries map straight through.
		o_mem_addr = 16'(s_q.base + s_q.item + (ctrl[ssq_pkg::CTRL_ONE_BASED] ? 16'h0000 : 16'h0001)); // see RQ4 see RQ5 see RQ6
	end

	// In hex framing two characters make one query byte.
	always_comb
	begin
		rx_ok = 1'b0;
		rx_val = i_rx_byte;
		if (i_rx_valid)
		begin
			if (!ctrl[ssq_pkg::CTRL_ASCII])
				rx_ok = 1'b1; // see RQ2
			else if (s_q.nib_ok)
			begin
				rx_ok = 1'b1;
				rx_val = {s_q.nib, hex_val(i_rx_byte)};
			end
		end
	end

	// Query decode, host memory walk, response build, loopback, host word port and indicators.
	always_comb
	begin
		s_d = s_q;
		ev_set = '0;
		s_d.gap = 1'b0;
		if (i_rx_valid && ctrl[ssq_pkg::CTRL_ASCII] && s_q.st != ST_LOOP)
		begin
			s_d.nib_ok = !s_q.nib_ok;
			s_d.nib = hex_val(i_rx_byte);
		end
		case (s_q.st)
			ST_IDLE, ST_RXQ:
			begin
				if (ctrl[ssq_pkg::CTRL_LOOPBACK] && s_q.st == ST_IDLE)
				begin
					s_d.st = ST_LOOP;
					s_d.loop_ch = ssq_pkg::LOOP_FIRST;
					s_d.tx_byte = ssq_pkg::LOOP_FIRST; // see RQ15
					s_d.nib_ok = 1'b0;
				end
				else if (rx_ok)
				begin
					// Collects class, address and count, then starts the host walk.
					s_d.st = ST_RXQ;
					s_d.nbytes = 3'(s_q.nbytes + 3'h1);
					case (s_q.nbytes)
						3'h0: s_d.cls = rx_val[1:0];
						3'h1: s_d.base[15:8] = rx_val;
						3'h2: s_d.base[7:0] = rx_val;
						3'h3: s_d.cnt[15:8] = rx_val;
						default: s_d.cnt[7:0] = rx_val;
					endcase
					if (s_q.nbytes == 3'(ssq_pkg::QUERY_BYTES - 3'h1))
					begin
						s_d.nbytes = '0;
						s_d.item = '0;
						s_d.sh = '0;
						s_d.bitn = '0;
						s_d.st = ST_HDR; // see RQ3
						// With the 32-bit option each register item is two host words.
						if (s_d.cls[1] && ctrl[ssq_pkg::CTRL_EXT32])
							s_d.cnt = {s_d.cnt[14:0], 1'b0}; // see RQ8
						s_d.tx_byte = s_d.cls[1] ? 8'({s_d.cnt[6:0], 1'b0}) : 8'(16'(s_d.cnt + 16'h0007) >> 3);
					end
				end
			end
			ST_HDR:
			begin
				// Sends the byte count, then asks the host for the first item.
				if (enc_ready)
					s_d.st = (s_q.cnt == '0) ? ST_DONE : ST_REQ;
			end
			ST_REQ:
			begin
				if (i_mem_ack)
				begin
					// The request drops for a cycle so the host never sees one request answered twice.
					s_d.gap = 1'b1; // see RQ3
					s_d.item = 16'(s_q.item + 16'h0001);
					if (discrete)
					begin
						s_d.sh = s_q.sh | (8'(i_mem_data[0]) << s_q.bitn); // see RQ9
						s_d.bitn = 3'(s_q.bitn + 3'h1);
						// Byte goes out full or at the last item with zero high bits.
						if (s_q.bitn == 3'h7 || s_d.item == s_q.cnt) // see RQ10
						begin
							s_d.tx_byte = s_d.sh;
							s_d.lowbyte = 1'b1;
							s_d.st = ST_EMIT;
						end
					end
					else
					begin
						s_d.wbuf = i_mem_data;
						s_d.tx_byte = i_mem_data[15:8];
						s_d.lowbyte = 1'b0;
						s_d.st = ST_EMIT;
					end
				end
			end
			ST_EMIT:
			begin
				if (enc_ready)
				begin
					if (!s_q.lowbyte)
					begin
						s_d.tx_byte = s_q.wbuf[7:0];
						s_d.lowbyte = 1'b1;
					end
					else
					begin
						s_d.sh = '0;
						s_d.bitn = '0;
						s_d.st = (s_q.item == s_q.cnt) ? ST_DONE : ST_REQ;
					end
				end
			end
			ST_DONE:
			begin
				ev_set[ssq_pkg::EV_DONE] = 1'b1;
				s_d.st = ST_IDLE;
				s_d.nib_ok = 1'b0;
			end
			default:
			begin
				// Loopback sends a rolling printable pattern until the mode is left.
				if (enc_ready)
				begin
					s_d.loop_ch = (s_q.loop_ch == ssq_pkg::LOOP_LAST) ? ssq_pkg::LOOP_FIRST :
						8'(s_q.loop_ch + 8'h01); // see RQ15
				end
				if (!ctrl[ssq_pkg::CTRL_LOOPBACK] && enc_ready)
					s_d.st = ST_IDLE;
				if (i_rx_valid)
					ev_set[ssq_pkg::EV_LOOP_RX] = 1'b1;
			end
		endcase
		if (s_q.st == ST_LOOP)
			s_d.tx_byte = s_d.loop_ch;
		// Bytes arriving while a query is being answered are dropped and flagged.
		if (i_rx_valid && (s_q.st == ST_REQ || s_q.st == ST_EMIT || s_q.st == ST_HDR))
			ev_set[ssq_pkg::EV_OVERRUN] = 1'b1;

		// Host word port: output words are stored, the clear word is write-one-to-clear.
		s_d.rdata = '0;
		if (i_wr)
		begin
			if (i_addr == ssq_pkg::OW_CLEAR)
				s_d.ev = s_q.ev & ~i_wdata[ssq_pkg::NUM_EV-1:0];
			else if (i_addr <= ssq_pkg::OW_LAST)
				s_d.wy[i_addr] = i_wdata; // see RQ1
		end
		s_d.ev = s_d.ev | ev_set;
		if (i_rd)
		begin
			if (i_addr == ssq_pkg::IW_STATUS)
				s_d.rdata = {6'h00, s_q.st, s_q.ev}; // see RQ1
			else if (i_addr == ssq_pkg::IW_COUNT)
				s_d.rdata = s_q.item;
			else if (i_addr == ssq_pkg::OW_CLEAR)
				s_d.rdata = '0;
			else
				s_d.rdata = s_q.wy[i_addr];
		end

		// Indicator stretchers and blink timer.
		s_d.tx_led = (o_tx_valid && i_tx_ready) ? HOLD : ((s_q.tx_led != '0) ? 32'(s_q.tx_led - 32'h1) : '0); // see RQ13
		s_d.rx_led = i_rx_valid ? HOLD : ((s_q.rx_led != '0) ? 32'(s_q.rx_led - 32'h1) : '0); // see RQ13
		if (s_q.blink >= 32'(HOLD - 32'h1))
		begin
			s_d.blink = '0;
			s_d.blink_on = !s_q.blink_on;
		end
		else
		begin
			s_d.blink = 32'(s_q.blink + 32'h1);
		end
	end

	// State register.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.wy[ssq_pkg::OW_CTRL] <= ssq_pkg::CTRL_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Response bytes pass through the framing encoder.
	ssq_hex_enc u_enc
	(
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_ascii(ctrl[ssq_pkg::CTRL_ASCII] && s_q.st != ST_LOOP),
		.i_valid(s_q.st == ST_HDR || s_q.st == ST_EMIT || s_q.st == ST_LOOP),
		.i_byte(s_q.tx_byte),
		.o_ready(enc_ready),
		.o_valid(o_tx_valid),
		.o_byte(o_tx_byte),
		.i_ready(i_tx_ready)
	);

	// Outputs.
	assign o_mem_req = (s_q.st == ST_REQ) && !s_q.gap; // see RQ3
	assign o_rdata = s_q.rdata;
	assign o_irq = |(s_q.ev & s_q.wy[ssq_pkg::OW_MASK][ssq_pkg::NUM_EV-1:0]);
	assign o_transmit_indicator = (s_q.tx_led != '0);
	assign o_receive_indicator = (s_q.rx_led != '0);
	assign o_active_led = i_diag_done && (!i_diag_fault || s_q.blink_on); // see RQ12

endmodule

/* File: verification/ssq_chk_sva.sv */
`timescale 1ns/10ps
// Watches the mapper ports for handshake, read port and indicator behaviour.
module ssq_chk
#(
	parameter int LED_HOLD_CYC = 4 // Indicator hold.
)
(
	input wire logic i_ref_clk, // Clock.
	input wire logic i_reset_n, // Reset, active low.
	input wire logic [2:0] i_addr, // Word index.
	input wire logic i_rd, // Read strobe.
	input wire logic [15:0] o_rdata, // Read data.
	input wire logic i_rx_valid, // Receive strobe.
	input wire logic o_tx_valid, // Transmit offer.
	input wire logic [7:0] o_tx_byte, // Transmit byte.
	input wire logic i_tx_ready, // Transmit take.
	input wire logic o_mem_req, // Memory request.
	input wire logic [2:0] o_mem_type, // Memory type.
	input wire logic [15:0] o_mem_addr, // Memory address.
	input wire logic i_mem_ack, // Memory reply.
	input wire logic i_diag_done, // Diagnostics done.
	input wire logic i_diag_fault, // Diagnostics fault.
	input wire logic o_active_led, // Active indicator.
	input wire logic o_transmit_indicator, // Transmit indicator.
	input wire logic o_receive_indicator // Receive indicator.
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	// A clean diagnostic result seen for three cycles in a row.
	sequence diag_ok;
		(i_diag_done && !i_diag_fault) [*3];
	endsequence
	AST_MEM_HOLD: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_type))
		else $error("memory request changed before reply");
	AST_MEM_GAP: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
		else $error("memory request not dropped after reply");
	AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
		else $error("transmit byte changed before taken");
	AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data without strobe");
	AST_CLR_READ: assert property (i_rd && i_addr == 3'h2 |=> o_rdata == 16'h0000)
		else $error("clear word read not zero");
	AST_TX_FLASH: assert property (o_tx_valid && i_tx_ready |-> ##[1:2] o_transmit_indicator)
		else $error("transmit indicator missing");
	AST_RX_FLASH: assert property (i_rx_valid |-> ##[1:2] o_receive_indicator)
		else $error("receive indicator missing");
	AST_LED_OFF: assert property (!i_diag_done && !$past(i_diag_done) |-> !o_active_led)
		else $error("active indicator lit before diagnostics");
	AST_LED_ON: assert property (diag_ok |-> o_active_led)
		else $error("active indicator not steady");
endmodule

/* File: verification/ssq_master_model.sv */
`timescale 1ns/10ps
// Remote master: sends query characters and collects the response stream.
module ssq_master_model
(
	input wire logic i_ref_clk, // Clock.
	input wire logic i_slow, // Stalls the slave on alternate cycles.
	input wire logic i_echo, // Loops each taken character back.
	output logic o_rx_valid, // Character strobe to the slave.
	output logic [7:0] o_rx_byte, // Character to the slave.
	input wire logic i_tx_valid, // Slave offers a character.
	input wire logic [7:0] i_tx_byte, // Slave character.
	output logic o_tx_ready // Character taken.
);
	logic [7:0] got[$];
	logic ph = 1'b0;
	initial
	begin
		o_rx_valid = 1'b0;
		o_rx_byte = 8'h00;
		o_tx_ready = 1'b1;
	end
	// Takes offered characters and echoes them back in loopback; an idle data line shows the inverse.
	always @(posedge i_ref_clk)
	begin
		ph <= !ph;
		o_tx_ready <= !i_slow || ph;
		if (i_tx_valid && o_tx_ready)
			got.push_back(i_tx_byte);
		if (i_echo)
		begin
			o_rx_valid <= i_tx_valid && o_tx_ready;
			o_rx_byte <= i_tx_valid && o_tx_ready ? i_tx_byte : ~o_rx_byte;
		end
	end
	// Sends one query character as a single strobe.
	task automatic send(input logic [7:0] b);
		@(posedge i_ref_clk);
		o_rx_valid <= 1'b1;
		o_rx_byte <= b;
		@(posedge i_ref_clk);
		o_rx_valid <= 1'b0;
		o_rx_byte <= ~b;
	endtask
endmodule

/* File: verification/test_ssq_query_mapper.sv */
`timescale 1ns/10ps
// Drives the host word and memory ports and checks the serial responses.
module test_ssq_query_mapper;
	typedef logic [7:0] ssq_bq_t[$];
	logic i_ref_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_mem_ack = 1'b0;
	logic i_diag_done = 1'b0;
	logic i_diag_fault = 1'b0;
	logic slow = 1'b0;
	logic echo = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic [15:0] i_mem_data = 16'h0000;
	logic [15:0] ctrl = 16'h0000;
	logic [15:0] r;
	logic [31:0] seed = 32'h0001155b; // Starts at 71003.
	logic [15:0] o_rdata, o_mem_addr;
	logic [7:0] o_tx_byte, rx_byte;
	logic [2:0] o_mem_type;
	logic o_irq, o_tx_valid, tx_ready, rx_valid, o_mem_req, o_active_led, o_transmit_indicator, o_receive_indicator;
	int bad_count = 0;
	int cmp_count = 0;
	ssq_query_mapper #(.LED_HOLD_CYC(4)) DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_rx_valid(rx_valid),
		.i_rx_byte(rx_byte), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .i_tx_ready(tx_ready),
		.o_mem_req(o_mem_req), .o_mem_type(o_mem_type), .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
		.i_mem_data(i_mem_data), .i_diag_done(i_diag_done), .i_diag_fault(i_diag_fault),
		.o_active_led(o_active_led), .o_transmit_indicator(o_transmit_indicator),
		.o_receive_indicator(o_receive_indicator));
	ssq_master_model m (.i_ref_clk(i_ref_clk), .i_slow(slow), .i_echo(echo), .o_rx_valid(rx_valid),
		.o_rx_byte(rx_byte), .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte), .o_tx_ready(tx_ready));
	// Clock at 200 MHz.
	initial
	begin
		forever #2.5 i_ref_clk = !i_ref_clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Host memory contents depend on both type and address.
	function automatic logic [15:0] mval(input logic [2:0] t, input logic [15:0] a);
		return {a[7:0] ^ {5'h00, t}, a[15:8] ^ 8'h3c ^ {7'h00, ^{a, t}}};
	endfunction
	function automatic logic [7:0] hx(input logic [3:0] n);
		return n < 4'ha ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction
	// Turns bytes into the line form of the current framing.
	function automatic ssq_bq_t enc(input ssq_bq_t s);
		ssq_bq_t o;
		foreach (s[i])
			if (ctrl[0])
				o = {o, hx(s[i][7:4]), hx(s[i][3:0])};
			else
				o.push_back(s[i]);
		return o;
	endfunction
	// The host answers each request after a random delay.
	always @(posedge i_ref_clk)
	begin
		i_mem_ack <= 1'b0;
		i_mem_data <= ~i_mem_data;
		if (o_mem_req && !i_mem_ack && 1'(rnd()))
		begin
			i_mem_ack <= 1'b1;
			i_mem_data <= mval(o_mem_type, o_mem_addr);
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		d = o_rdata;
	endtask
	task automatic query(input logic [1:0] c, input logic [15:0] a, input logic [15:0] n);
		ssq_bq_t q;
		ssq_bq_t e;
		logic [15:0] b;
		logic [15:0] w;
		logic [7:0] d;
		logic [2:0] t;
		q = '{{6'h00, c}, a[15:8], a[7:0], n[15:8], n[7:0]};
		if (c[1] && ctrl[3])
			n = n << 1;
		b = ctrl[1] ? a : a + 16'h0001;
		d = 8'h00;
		case (c)
			ssq_pkg::CLS_COIL: t = ctrl[2] || ctrl[3] ? ssq_pkg::MEM_INTERNAL_RELAY : ssq_pkg::MEM_DISCRETE_OUT;
			ssq_pkg::CLS_INPUT: t = ssq_pkg::MEM_DISCRETE_IN;
			ssq_pkg::CLS_HOLDING: t = ssq_pkg::MEM_VARIABLE;
			default: t = ssq_pkg::MEM_PLC_INPUT_WORD;
		endcase
		e.push_back(c[1] ? 8'(n << 1) : 8'((n + 16'h0007) >> 3));
		for (int i = 0; i < n; i++)
		begin
			w = mval(t, b + 16'(i));
			if (c[1])
				e = {e, w[15:8], w[7:0]};
			else
				d[i % 8] = w[0];
			if (!c[1] && (i % 8 == 7 || i == n - 1))
			begin
				e.push_back(d);
				d = 8'h00;
			end
		end
		m.got.delete();
		q = enc(q);
		e = enc(e);
		foreach (q[i])
			m.send(q[i]);
		for (int i = 0; i < 4000 && m.got.size() < e.size(); i++)
			@(posedge i_ref_clk);
		repeat (6) @(posedge i_ref_clk);
		chk(16'(m.got.size()), 16'(e.size()));
		foreach (e[i])
			chk({8'h00, m.got[i]}, {8'h00, e[i]});
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog for a hung run.
	initial
	begin
		repeat (90000) @(posedge i_ref_clk);
		bad_count++;
		wrap_up();
	end
	// Main sequence.
	initial
	begin
		int n;
		logic p;
		repeat (20) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		rd(3'h0, r);
		chk(r, 16'h0000);
		rd(3'h6, r);
		chk(r, 16'h0008);
		chk(16'(o_active_led), 16'h0000);
		i_diag_done <= 1'b1;
		wr(3'h6, 16'hffff);
		rd(3'h6, r);
		chk(r, 16'h0008);
		for (int i = 2; i < 6; i++)
		begin
			void'(rnd());
			wr(3'(i), 16'(seed));
			rd(3'(i), r);
			chk(r, i == 2 ? 16'h0000 : 16'(seed));
		end
		chk(16'(o_active_led), 16'h0001);
		wr(3'h1, 16'h0007);
		for (int k = 0; k < 17; k++)
		begin
			ctrl = {12'h000, k >= 15, 1'(rnd()), k[3], k[2]};
			slow <= 1'(rnd());
			wr(3'h0, ctrl);
			query(k[1:0], 16'(k == 0 ? 0 : k == 8 ? 1 : rnd() % 200 + 1),
				16'(k == 0 ? 10 : k[1] ? rnd() % 4 + 1 : rnd() % 20 + 1));
			rd(3'h6, r);
			chk(r & 16'h0007, 16'h0001);
			chk(16'(o_irq), 16'h0001);
			wr(3'h2, 16'h0007);
			@(negedge i_ref_clk);
			chk(16'(o_irq), 16'h0000);
		end
		m.got.delete();
		slow <= 1'b0;
		echo <= 1'b1;
		wr(3'h0, 16'h0010);
		repeat (40) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		for (int i = 0; i < 4; i++)
			chk({8'h00, m.got[i]}, 16'h0020 + 16'(i));
		chk(16'(o_transmit_indicator && o_receive_indicator), 16'h0001);
		rd(3'h6, r);
		chk(r & 16'h0004, 16'h0004);
		wr(3'h0, 16'h0000);
		echo <= 1'b0;
		i_diag_fault <= 1'b1;
		n = 0;
		p = o_active_led;
		repeat (24)
		begin
			@(negedge i_ref_clk);
			n += int'(o_active_led !== p);
			p = o_active_led;
		end
		chk(16'(n >= 3), 16'h0001);
		wrap_up();
	end
endmodule
bind ssq_query_mapper ssq_chk #(.LED_HOLD_CYC(LED_HOLD_CYC)) chk_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
	.i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(i_rx_valid), .o_tx_valid(o_tx_valid),
	.o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready), .o_mem_req(o_mem_req), .o_mem_type(o_mem_type),
	.o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack), .i_diag_done(i_diag_done), .i_diag_fault(i_diag_fault),
	.o_active_led(o_active_led), .o_transmit_indicator(o_transmit_indicator),
	.o_receive_indicator(o_receive_indicator));
